// ===== cfg_hdr_regs.sv
// Bridge configuration header: status, revision, class code and master time slice over APB.
//
// Contract
// - Status resets 0280h; W1C and read-only fields.
// - Target parity error sets bit 15 always.
// - Driving system error sets bit 14.
// - Unexpected master abort sets bit 13.
// - Received target abort sets 12, may signal.
// - Sending target abort sets bit 11.
// - Select timing field constant 01b.
// - Bit 8 needs PERR, initiator, report enable.
// - Bit 7 reads one; 6:0 reserved.
// - Only writing one clears a flag.
// - Revision number at 08h, read only.
// - Class code constant 060000h, read only.
// - Time slice bits 7:3 writable, 2:0 zero.
// - Expired slice: finish phase, yield without grant.
// - Time slice resets zero; zero disables limit.
// - Parity report enable gates PERR reporting.
// - System error enable gates SERR drive.
`timescale 1ns/1ps
module cfg_hdr_regs
#(
    parameter logic [7:0] REVISION = 8'h01  // Arbitrary value.
)
(
    // Clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic             PREADY_O,
    output logic [31:0]      PRDATA_O,
    output logic             PSLVERR_O,
    // Bus event pulses from the bridge logic
    input  wire logic        TGT_PARITY_ERR_I,
    input  wire logic        SERR_REQ_I,
    input  wire logic        MASTER_ABORT_I,
    input  wire logic        SPECIAL_CYCLE_I,
    input  wire logic        TARGET_ABORT_RX_I,
    input  wire logic        TARGET_ABORT_TX_I,
    input  wire logic        PERR_SEEN_I,
    input  wire logic        INITIATOR_I,
    input  wire logic        TARGET_ABORT_SERR_EN_I,
    // Master tenure
    input  wire logic        MASTER_TENURE_I,
    input  wire logic        GRANT_I,
    input  wire logic        DATA_PHASE_DONE_I,
    // Error outputs and tenure release
    output logic             SERR_O,
    output logic             PERR_REPORT_O,
    output logic             RELEASE_BUS_O,
    output logic             IRQ_O
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [7:0]  slice_q;
    logic [7:0]  slice_d;
    logic [1:0]  control_q;
    logic [1:0]  control_d;
    logic [5:0]  irq_stat_q;
    logic [5:0]  irq_stat_d;
    logic [5:0]  irq_mask_q;
    logic [5:0]  irq_mask_d;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        serr_q;
    logic        perr_q;
    logic        release_q;
    logic        irq_q;
    logic        wait_phase_q;
    logic        wait_phase_d;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Access completes in the second access cycle; byte address is index times four.
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[11:2] == {2'h0, idx});
    endfunction

    wire         access     = PSEL_I && PENABLE_I && !pready_q;
    wire         wr         = access && PWRITE_I;
    wire         hit_status = hit(PADDR_I, cfg_hdr_pkg::IDX_BUS_STATUS);
    wire         hit_rev    = hit(PADDR_I, cfg_hdr_pkg::IDX_REVISION);
    wire         hit_class  = hit(PADDR_I, cfg_hdr_pkg::IDX_DEVICE_CLASS);
    wire         hit_slice  = hit(PADDR_I, cfg_hdr_pkg::IDX_TIME_SLICE);
    wire         hit_ctl    = hit(PADDR_I, cfg_hdr_pkg::IDX_CONTROL);
    wire         hit_istat  = hit(PADDR_I, cfg_hdr_pkg::IDX_IRQ_STATUS);
    wire         hit_imask  = hit(PADDR_I, cfg_hdr_pkg::IDX_IRQ_MASK);
    wire         hit_sstate = hit(PADDR_I, cfg_hdr_pkg::IDX_SLICE_STATE);
    wire         mapped     = hit_status | hit_rev | hit_class | hit_slice |
                              hit_ctl | hit_istat | hit_imask | hit_sstate;
    wire [15:0]  wdata16    = {PSTRB_I[1] ? PWDATA_I[15:8] : 8'h00, PSTRB_I[0] ? PWDATA_I[7:0] : 8'h00};
    wire         wr_low     = wr && PSTRB_I[0];

    // ------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------
    wire parity_report = control_q[cfg_hdr_pkg::CTL_PARITY_REPORT];
    wire syserr_enable = control_q[cfg_hdr_pkg::CTL_SYSERR_ENABLE];
    // Special cycles end in master abort by design.
    wire ev_mabort     = MASTER_ABORT_I && !SPECIAL_CYCLE_I;
    // All three conditions must meet together.
    wire ev_init_par   = PERR_SEEN_I && INITIATOR_I && parity_report;
    // Received target abort may request system error.
    wire serr_cause    = SERR_REQ_I || (TARGET_ABORT_RX_I && TARGET_ABORT_SERR_EN_I);
    // No system error drive while disabled.
    wire serr_fire     = serr_cause && syserr_enable;
    // Target parity sets regardless of enables.
    wire [15:0] set_vec = {TGT_PARITY_ERR_I, serr_fire, ev_mabort, TARGET_ABORT_RX_I,
                           TARGET_ABORT_TX_I, 2'b00, ev_init_par, 8'h00};

    // ------------------------------------------------------------------
    // Status next value
    // ------------------------------------------------------------------
    // Only ones written clear; a same-cycle event wins over the clear.
    wire [15:0] clr_vec = (wr && hit_status) ? (wdata16 & cfg_hdr_pkg::STATUS_W1C_MASK) : 16'h0000;
    // Read-only bits are rebuilt from constants every cycle.
    assign status_d = (((status_q & ~clr_vec) | set_vec) & cfg_hdr_pkg::STATUS_W1C_MASK)
                    | {5'h00, cfg_hdr_pkg::SELECT_TIMING, 1'b0, 1'b1, 7'h00};

    // Low three slice bits never store.
    assign slice_d   = (wr_low && hit_slice) ? (PWDATA_I[7:0] & cfg_hdr_pkg::SLICE_WR_MASK) : slice_q;
    assign control_d = (wr_low && hit_ctl) ? PWDATA_I[1:0] : control_q;
    assign irq_mask_d = (wr_low && hit_imask) ? PWDATA_I[5:0] : irq_mask_q;
    // Interrupt status: one bit per event, set wins over write-one clear.
    wire [5:0] irq_ev = {TGT_PARITY_ERR_I, serr_fire, ev_mabort, TARGET_ABORT_RX_I,
                         TARGET_ABORT_TX_I, ev_init_par};
    assign irq_stat_d = (irq_stat_q & ~((wr_low && hit_istat) ? PWDATA_I[5:0] : 6'h00)) | irq_ev;

    // ------------------------------------------------------------------
    // Time slice
    // ------------------------------------------------------------------
    logic       expired;
    logic [7:0] slice_count;

    // Zero setting keeps the timer silent.
    slice_timer u_slice
    (
        .clk_i     (REF_CLK_I),
        .rst_i     (RESET_I),
        .tenure_i  (MASTER_TENURE_I),
        .slice_i   (slice_q),
        .expired_o (expired),
        .count_o   (slice_count)
    );

    // After expiry wait for the current data phase, then yield once grant is gone.
    assign wait_phase_d = MASTER_TENURE_I && expired && (wait_phase_q || DATA_PHASE_DONE_I);
    wire   release_d    = MASTER_TENURE_I && expired && (wait_phase_q || DATA_PHASE_DONE_I) && !GRANT_I;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Unmapped bits read zero.
    wire [31:0] rdata =
        hit_status ? {16'h0000, status_q} :
        hit_rev    ? {24'h000000, REVISION} :
        hit_class  ? {8'h00, cfg_hdr_pkg::DEVICE_CLASS} :
        hit_slice  ? {24'h000000, slice_q} :
        hit_ctl    ? {30'h0, control_q} :
        hit_istat  ? {26'h0, irq_stat_q} :
        hit_imask  ? {26'h0, irq_mask_q} :
        hit_sstate ? {23'h0, expired, slice_count} : 32'h00000000;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Configuration storage; reset values are constants.
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            status_q   <= cfg_hdr_pkg::STATUS_RESET;
            slice_q    <= cfg_hdr_pkg::SLICE_RESET;
            control_q  <= cfg_hdr_pkg::CONTROL_RESET;
            irq_stat_q <= cfg_hdr_pkg::IRQ_MASK_RESET;
            irq_mask_q <= cfg_hdr_pkg::IRQ_MASK_RESET;
        end
        else
        begin
            status_q   <= status_d;
            slice_q    <= slice_d;
            control_q  <= control_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Bus answer and output flops; each output comes straight from a flop.
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            pready_q     <= 1'b0;
            prdata_q     <= 32'h00000000;
            pslverr_q    <= 1'b0;
            serr_q       <= 1'b0;
            perr_q       <= 1'b0;
            release_q    <= 1'b0;
            irq_q        <= 1'b0;
            wait_phase_q <= 1'b0;
        end
        else
        begin
            pready_q     <= access;
            prdata_q     <= (access && !PWRITE_I) ? rdata : 32'h00000000;
            pslverr_q    <= access && !mapped;
            serr_q       <= serr_fire;
            perr_q       <= PERR_SEEN_I && parity_report;
            release_q    <= release_d;
            irq_q        <= |(irq_stat_d & irq_mask_q);
            wait_phase_q <= wait_phase_d;
        end
    end

    assign PREADY_O      = pready_q;
    assign PRDATA_O      = prdata_q;
    assign PSLVERR_O     = pslverr_q;
    // System error drive and bit 14 come from the same cause.
    assign SERR_O        = serr_q;
    // Parity reporting gated by the enable.
    assign PERR_REPORT_O = perr_q;
    assign RELEASE_BUS_O = release_q;
    assign IRQ_O         = irq_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_RO_FIELDS: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        status_q[10:9] == 2'b01 && status_q[7] && status_q[6:0] == 7'h00)
        else $error("Status constant fields wrong.");

    AST_PARITY_SET: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        TGT_PARITY_ERR_I |=> status_q[15])
        else $error("Target parity error not recorded.");

    AST_SERR_FLAG: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        $rose(SERR_O) |-> status_q[14])
        else $error("System error without status bit.");

    AST_MABORT: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (MASTER_ABORT_I && SPECIAL_CYCLE_I && !status_q[13]) |=> !status_q[13])
        else $error("Special cycle abort set status.");

    AST_TABORT_RX: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        TARGET_ABORT_RX_I |=> status_q[12])
        else $error("Received target abort not recorded.");

    AST_TABORT_TX: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        TARGET_ABORT_TX_I |=> status_q[11])
        else $error("Sent target abort not recorded.");

    AST_INIT_PARITY: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (!status_q[8] && !(PERR_SEEN_I && INITIATOR_I && control_q[0])) |=> !status_q[8])
        else $error("Initiator parity flag set without cause.");

    AST_HOLD_ZERO: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (wr && hit_status && PSTRB_I[1] && !PWDATA_I[15] && status_q[15]) |=> status_q[15])
        else $error("Zero write cleared a flag.");

    AST_SLICE_LOW: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        slice_q[2:0] == 3'b000)
        else $error("Time slice low bits nonzero.");

    AST_SLICE_OFF: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (slice_q == 8'h00) |=> !expired)
        else $error("Zero slice expired.");

    AST_SERR_GATE: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !control_q[1] |=> !SERR_O)
        else $error("System error driven while disabled.");

    AST_APB_ONE: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (PSEL_I && PENABLE_I && !pready_q) |=> PREADY_O ##1 !PREADY_O)
        else $error("APB answer timing wrong.");

    AST_PERR_GATE: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !control_q[cfg_hdr_pkg::CTL_PARITY_REPORT] |=> !PERR_REPORT_O)
        else $error("Parity reported while disabled.");

    AST_SERR_CAUSE: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (TARGET_ABORT_RX_I && TARGET_ABORT_SERR_EN_I && control_q[cfg_hdr_pkg::CTL_SYSERR_ENABLE]) |=> SERR_O)
        else $error("Enabled target abort did not signal.");

    AST_W1C_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        (wr && hit_status && PSTRB_I[1] && PWDATA_I[11] && !TARGET_ABORT_TX_I) |=> !status_q[11])
        else $error("Write of one did not clear a flag.");

    AST_RELEASE_GRANT: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        GRANT_I |=> !RELEASE_BUS_O)
        else $error("Bus released while still granted.");

    AST_RELEASE_EXPIRED: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
        !expired |=> !RELEASE_BUS_O)
        else $error("Bus released before slice expiry.");
endmodule

// ===== cfg_hdr_pkg.sv
// Package with offsets, reset values and field positions of the bridge configuration header block.
package cfg_hdr_pkg;

    // ------------------------------------------------------------------
    // Register indices as printed; APB byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_BUS_STATUS   = 8'h06;
    localparam logic [7:0]  IDX_REVISION     = 8'h08;
    localparam logic [7:0]  IDX_DEVICE_CLASS = 8'h09;
    localparam logic [7:0]  IDX_TIME_SLICE   = 8'h0d;
    localparam logic [7:0]  IDX_CONTROL      = 8'h20;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h21;
    localparam logic [7:0]  IDX_IRQ_MASK     = 8'h22;
    localparam logic [7:0]  IDX_SLICE_STATE  = 8'h23;

    // ------------------------------------------------------------------
    // Reset and constant values
    // ------------------------------------------------------------------
    localparam logic [15:0] STATUS_RESET     = 16'h0280;
    localparam logic [15:0] STATUS_W1C_MASK  = 16'hf900;
    localparam logic [1:0]  SELECT_TIMING    = 2'h1;
    localparam logic [23:0] DEVICE_CLASS     = 24'h060000;
    localparam logic [7:0]  SLICE_RESET      = 8'h00;
    localparam logic [7:0]  SLICE_WR_MASK    = 8'hf8;
    localparam logic [1:0]  CONTROL_RESET    = 2'h0;
    localparam logic [5:0]  IRQ_MASK_RESET   = 6'h00;

    // ------------------------------------------------------------------
    // Status and control bit positions
    // ------------------------------------------------------------------
    localparam int BIT_PARITY_SEEN   = 15;
    localparam int BIT_SYSERR        = 14;
    localparam int BIT_MASTER_ABORT  = 13;
    localparam int BIT_TARGET_ABORT  = 12;
    localparam int BIT_SENT_ABORT    = 11;
    localparam int BIT_INIT_PARITY   = 8;
    localparam int BIT_BACK_TO_BACK  = 7;
    localparam int CTL_PARITY_REPORT = 0;
    localparam int CTL_SYSERR_ENABLE = 1;

endpackage

// ===== slice_timer.sv
// Master time-slice counter for the bus master side of the bridge.
`timescale 1ns/1ps
module slice_timer
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Tenure and setting
    input  wire logic       tenure_i,
    input  wire logic [7:0] slice_i,
    // Expiry level and count
    output logic            expired_o,
    output logic [7:0]      count_o
);
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic       expired_q;
    logic       expired_d;

    // Counter loads on each tenure start; a zero setting never expires.
    assign count_d   = !tenure_i ? slice_i : (count_q != 8'h00 ? count_q - 8'h01 : count_q);
    assign expired_d = tenure_i && (slice_i != 8'h00) && (count_q == 8'h01 || expired_q);

    // Count and expiry flags.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_q   <= 8'h00;
            expired_q <= 1'b0;
        end
        else
        begin
            count_q   <= count_d;
            expired_q <= expired_d;
        end
    end

    assign expired_o = expired_q;
    assign count_o   = count_q;
endmodule

// ===== bus_side_model.sv
// Behavioural model of the bus agents and arbiter that feed the bridge its events.
`timescale 1ns/1ps
module bus_side_model
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Requests from the bench
    input  wire logic [5:0] event_req_i,
    input  wire logic [2:0] qual_req_i,
    input  wire logic       tenure_req_i,
    input  wire logic       grant_req_i,
    // Bridge-facing signals
    output logic [5:0]      events_o,
    output logic [2:0]      quals_o,
    output logic            tenure_o,
    output logic            grant_o,
    output logic            phase_done_o
);
    // Events leave as one-cycle pulses; the initiator and special-cycle qualifiers are inverted outside
    // an event so that a design which ignores their timing does not pass by luck.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            events_o     <= 6'h00;
            quals_o      <= 3'h0;
            tenure_o     <= 1'b0;
            grant_o      <= 1'b0;
            phase_done_o <= 1'b0;
        end
        else
        begin
            events_o     <= event_req_i;
            quals_o      <= {qual_req_i[2], (|event_req_i) ? qual_req_i[1:0] : ~qual_req_i[1:0]};
            tenure_o     <= tenure_req_i;
            grant_o      <= grant_req_i;
            phase_done_o <= tenure_req_i & ~phase_done_o;  // A burst ends a data phase every other clock.
        end
    end
endmodule

// ===== tb.sv
// Self-checking bench for the bridge configuration header block.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------------
    // Signals and expectation table
    // ------------------------------------------------------------------
    localparam logic [7:0] REV = 8'h5a;  // Arbitrary revision value.
    // Row: control, qualifiers {serr en, initiator, special}, event, {serr, perr}, status.
    localparam logic [31:0] CASES [11] = '{32'h0000_8280, 32'h2012_4280, 32'h0010_0280,
        32'h0020_2280, 32'h0120_0280, 32'h2432_5280, 32'h0430_1280, 32'h0040_0a80,
        32'h1251_0380, 32'h1051_0280, 32'h0250_0280};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, serr, perr_rep, release_bus, irq, err, serr_seen, perr_seen;
    logic [5:0]  ev_req = 6'h00;
    logic [5:0]  events;
    logic [2:0]  qual_req = 3'h0;
    logic [2:0]  quals;
    logic        ten_req = 1'b0;
    logic        grant_req = 1'b0;
    logic        tenure, grant, phase_done;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #4 clk = ~clk;

    cfg_hdr_regs #(.REVISION(REV)) u_cfg_hdr_regs (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .TGT_PARITY_ERR_I(events[0]),
        .SERR_REQ_I(events[1]), .MASTER_ABORT_I(events[2]), .SPECIAL_CYCLE_I(quals[0]),
        .TARGET_ABORT_RX_I(events[3]), .TARGET_ABORT_TX_I(events[4]), .PERR_SEEN_I(events[5]),
        .INITIATOR_I(quals[1]), .TARGET_ABORT_SERR_EN_I(quals[2]), .MASTER_TENURE_I(tenure),
        .GRANT_I(grant), .DATA_PHASE_DONE_I(phase_done), .SERR_O(serr), .PERR_REPORT_O(perr_rep),
        .RELEASE_BUS_O(release_bus), .IRQ_O(irq));

    bus_side_model u_bus_side_model (.clk_i(clk), .rst_i(rst), .event_req_i(ev_req),
        .qual_req_i(qual_req), .tenure_req_i(ten_req), .grant_req_i(grant_req), .events_o(events),
        .quals_o(quals), .tenure_o(tenure), .grant_o(grant), .phase_done_o(phase_done));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; data is taken at the edge where ready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask

    // Request one event; sample the error outputs one edge after the pulse lands.
    task automatic fire(input logic [2:0] ev, input logic [2:0] q);
        @(posedge clk);
        ev_req   <= 6'h01 << ev;
        qual_req <= q;
        @(posedge clk);
        ev_req <= 6'h00;
        @(posedge clk);
        @(negedge clk);
        serr_seen = serr;
        perr_seen = perr_rep;
    endtask

    // Waits a bounded time so a dead release path is reported, not hung on.
    // Returns just after a rising edge so the caller drives its inputs there.
    task automatic wait_release(input int max);
        repeat (max)
        begin
            @(negedge clk);
            if (release_bus === 1'b1)
                break;
        end
        chk({31'h0, release_bus}, 32'h1);
        @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rchk(cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_0280);
        rchk(cfg_hdr_pkg::IDX_REVISION, {24'h0, REV});
        rchk(cfg_hdr_pkg::IDX_DEVICE_CLASS, 32'h0006_0000);
        rchk(cfg_hdr_pkg::IDX_TIME_SLICE, 32'h0);
        apb(1'b1, cfg_hdr_pkg::IDX_REVISION, 32'hffff_ffff);
        apb(1'b1, cfg_hdr_pkg::IDX_DEVICE_CLASS, 32'hffff_ffff);
        apb(1'b1, cfg_hdr_pkg::IDX_BUS_STATUS, 32'hffff_06ff);
        apb(1'b1, cfg_hdr_pkg::IDX_TIME_SLICE, 32'h0000_00ff);
        rchk(cfg_hdr_pkg::IDX_REVISION, {24'h0, REV});
        rchk(cfg_hdr_pkg::IDX_DEVICE_CLASS, 32'h0006_0000);
        rchk(cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_0280);
        rchk(cfg_hdr_pkg::IDX_TIME_SLICE, 32'h0000_00f8);
        $display("test reset_and_readonly done");
        foreach (CASES[i])
        begin
            apb(1'b1, cfg_hdr_pkg::IDX_CONTROL, {30'h0, CASES[i][29:28]});
            fire(CASES[i][22:20], CASES[i][26:24]);
            chk({30'h0, serr_seen, perr_seen}, {30'h0, CASES[i][17:16]});
            rchk(cfg_hdr_pkg::IDX_BUS_STATUS, {16'h0, CASES[i][15:0]});
            apb(1'b1, cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_ffff);
            apb(1'b1, cfg_hdr_pkg::IDX_IRQ_STATUS, 32'h0000_003f);
        end
        $display("test error_events done");
        apb(1'b1, cfg_hdr_pkg::IDX_CONTROL, 32'h0);
        fire(3'd0, 3'h0);
        fire(3'd4, 3'h0);
        apb(1'b1, cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_0000);
        rchk(cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_8a80);
        apb(1'b1, cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_0800);
        rchk(cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_8280);
        apb(1'b1, cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_8000);
        rchk(cfg_hdr_pkg::IDX_BUS_STATUS, 32'h0000_0280);
        $display("test clear_by_one done");
        // A mask bit of one lets its status bit through to the interrupt.
        apb(1'b1, cfg_hdr_pkg::IDX_IRQ_STATUS, 32'h0000_003f);
        apb(1'b1, cfg_hdr_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        fire(3'd4, 3'h0);
        chk({31'h0, irq}, 32'h0);
        rchk(cfg_hdr_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
        apb(1'b1, cfg_hdr_pkg::IDX_IRQ_MASK, 32'h0000_003f);
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, cfg_hdr_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1);
        $display("test irq_and_unmapped done");
        apb(1'b1, cfg_hdr_pkg::IDX_TIME_SLICE, 32'h0000_0008);
        @(posedge clk);
        ten_req   <= 1'b1;
        grant_req <= 1'b1;
        repeat (20) @(negedge clk);
        chk({31'h0, release_bus}, 32'h0);
        rchk(cfg_hdr_pkg::IDX_SLICE_STATE, 32'h0000_0100);
        grant_req <= 1'b0;
        wait_release(10);
        ten_req <= 1'b0;
        repeat (4) @(posedge clk);
        ten_req <= 1'b1;
        repeat (4) @(negedge clk);
        chk({31'h0, release_bus}, 32'h0);
        wait_release(20);
        ten_req <= 1'b0;
        apb(1'b1, cfg_hdr_pkg::IDX_TIME_SLICE, 32'h0);
        ten_req <= 1'b1;
        repeat (40) @(negedge clk);
        chk({31'h0, release_bus}, 32'h0);
        $display("test time_slice done");
        close_out();
    end
endmodule
